/* rtl/usb_ep0_regs.vh */
// register offsets, field positions and reset values for the ep0 register set
`ifndef USB_EP0_REGS_VH
`define USB_EP0_REGS_VH
`define ADDR_IN_CONFIG 16'hff80
`define ADDR_IN_COUNT 16'hff81
`define ADDR_OUT_CONFIG 16'hff82
`define ADDR_OUT_COUNT 16'hff83
`define ADDR_CONTROL 16'hfffc
`define ADDR_MASK 16'hfffd
`define ADDR_FLAGS 16'hfffe
`define ADDR_FUNC 16'hffff
`define OUT_BUF_BASE 16'hfef0
`define IN_BUF_BASE 16'hfef8
`define CFG_IRQ_EN 2
`define CFG_STALL 3
`define CFG_TOGGLE 5
`define CFG_MGR_EN 7
`define CNT_NAK 7
`define CNT_MAX 4'h8
`define FLG_OVERWRITE 0
`define FLG_WAKEUP 1
`define FLG_SETUP 2
`define FLG_RING 3
`define FLG_RESUME 5
`define FLG_SUSPEND 6
`define FLG_RESETREQ 7
`define FLG_USED 8'hef
`define CTL_DIR 0
`define CTL_SERVICE 1
`define CTL_LINK 4
`define CTL_WAKEUP 5
`define CTL_CONNECT 7
`define CTL_WMASK 8'hd3
`define CTL_RESET 8'h10
`define CNT_RESET 8'h80
`endif

/* rtl/usb_ep0_ctrl.v */
// endpoint-0 descriptors, address, event flags and control over axi4-lite
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "usb_ep0_regs.vh"
module usb_ep0_ctrl (
    input wire clock,
    input wire sys_rst,
    input wire funcRst,
    // axi4-lite slave
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // serial engine events, same clock
    input wire setupRx,
    input wire setupHeld,
    input wire inDone,
    input wire outDone,
    input wire outPacketRx,
    input wire inToggle,
    input wire outToggle,
    input wire suspendSeen,
    input wire resumeSeen,
    input wire portReset,
    // pins from outside
    input wire ringPin,
    input wire wakeupPin,
    // answers to the serial engine
    output reg inNak,
    output reg outNak,
    output reg inStall,
    output reg outStall,
    output reg inMgrEnable,
    output reg outMgrEnable,
    output reg [3:0] inByteCount,
    output reg [3:0] outByteCount,
    output reg [15:0] inBufBase,
    output reg [15:0] outBufBase,
    output reg [6:0] assignedAddress,
    output reg dataDirIn,
    output reg setupService,
    output reg infraredSelect,
    output reg pullupEnable,
    output reg wakeupPulse,
    output reg mcuReset,
    output reg epIrq,
    output reg eventIrq
);

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg [7:0] inCfg;
reg [7:0] outCfg;
reg [7:0] inCnt;
reg [7:0] outCnt;
reg [7:0] usbControl;
reg [7:0] eventMask;
reg [7:0] eventFlags;
reg [6:0] funcAddr;
reg [1:0] ringSync;
reg [1:0] wakeSync;
reg ringLast;
reg wakeLast;
reg [15:0] wrAddr;
reg [7:0] wrData;
reg wrLane;
reg haveAw;
reg haveW;
reg [7:0] wrHit;

// write select positions, one per register
localparam SEL_IN_CFG = 0;
localparam SEL_IN_CNT = 1;
localparam SEL_OUT_CFG = 2;
localparam SEL_OUT_CNT = 3;
localparam SEL_CTL = 4;
localparam SEL_MASK = 5;
localparam SEL_FLAGS = 6;
localparam SEL_FUNC = 7;

wire usbRst = sys_rst | funcRst;
wire wrFire = haveAw & haveW & ~s_axi_bvalid;
wire wrOk = wrFire & wrLane;
wire ringRise = ringSync[1] & ~ringLast;
wire wakeRise = wakeSync[1] & ~wakeLast;
wire [7:0] flagSet;
wire [7:0] flagClr;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        ringSync <= 2'h0;
        wakeSync <= 2'h0;
        ringLast <= 1'b0;
        wakeLast <= 1'b0;
    end else begin
        ringSync <= {ringSync[0], ringPin};
        wakeSync <= {wakeSync[0], wakeupPin};
        ringLast <= ringSync[1];
        wakeLast <= wakeSync[1];
    end
end

// ----------------------------------------------------------------
// axi write channel capture
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        wrAddr <= 16'h0;
        wrData <= 8'h0;
        wrLane <= 1'b0;
    end else begin
        s_axi_awready <= ~haveAw & ~s_axi_awready & ~s_axi_bvalid;
        s_axi_wready <= ~haveW & ~s_axi_wready & ~s_axi_bvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            haveAw <= 1'b1;
            s_axi_awready <= 1'b0;
            wrAddr <= s_axi_awaddr[17:2]; // index from byte address
        end
        if (s_axi_wvalid & s_axi_wready) begin
            haveW <= 1'b1;
            s_axi_wready <= 1'b0;
            wrData <= s_axi_wdata[7:0];
            wrLane <= s_axi_wstrb[0];
        end
        if (wrFire) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// write address decode, one select bit per register
// ----------------------------------------------------------------
always @* begin
    wrHit = 8'h0;
    if (!wrOk) begin
        wrHit = 8'h0; // no complete write with byte lane 0 enabled this cycle
    end else if (wrAddr == `ADDR_IN_CONFIG) begin
        wrHit[SEL_IN_CFG] = 1'b1;
    end else if (wrAddr == `ADDR_IN_COUNT) begin
        wrHit[SEL_IN_CNT] = 1'b1;
    end else if (wrAddr == `ADDR_OUT_CONFIG) begin
        wrHit[SEL_OUT_CFG] = 1'b1;
    end else if (wrAddr == `ADDR_OUT_COUNT) begin
        wrHit[SEL_OUT_CNT] = 1'b1;
    end else if (wrAddr == `ADDR_CONTROL) begin
        wrHit[SEL_CTL] = 1'b1;
    end else if (wrAddr == `ADDR_MASK) begin
        wrHit[SEL_MASK] = 1'b1;
    end else if (wrAddr == `ADDR_FLAGS) begin
        wrHit[SEL_FLAGS] = 1'b1;
    end else if (wrAddr == `ADDR_FUNC) begin
        wrHit[SEL_FUNC] = 1'b1;
    end
end

// ----------------------------------------------------------------
// endpoint-0 descriptors, reset by power-up or function reset (counts reload with nak set)
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (usbRst) begin
        inCfg <= 8'h0;
        outCfg <= 8'h0;
        inCnt <= `CNT_RESET;
        outCnt <= `CNT_RESET;
        funcAddr <= 7'h0;
    end else begin
        // firmware writes only the writable bits
        if (wrHit[SEL_IN_CFG]) begin
            inCfg[`CFG_MGR_EN] <= wrData[`CFG_MGR_EN];
            inCfg[`CFG_STALL] <= wrData[`CFG_STALL];
            inCfg[`CFG_IRQ_EN] <= wrData[`CFG_IRQ_EN];
        end
        if (wrHit[SEL_OUT_CFG]) begin
            outCfg[`CFG_MGR_EN] <= wrData[`CFG_MGR_EN];
            outCfg[`CFG_STALL] <= wrData[`CFG_STALL];
            outCfg[`CFG_IRQ_EN] <= wrData[`CFG_IRQ_EN];
        end
        if (wrHit[SEL_IN_CNT]) begin
            inCnt <= {wrData[`CNT_NAK], 3'h0, wrData[3:0]};
        end
        if (wrHit[SEL_OUT_CNT]) begin
            outCnt <= {wrData[`CNT_NAK], 3'h0, wrData[3:0]};
        end
        if (wrHit[SEL_FUNC]) begin
            funcAddr <= wrData[6:0];
        end
        // hardware updates win over firmware writes
        if (setupRx) begin
            inCfg[`CFG_STALL] <= 1'b0;
        end
        if (outCfg[`CFG_STALL] & outDone) begin
            outCfg[`CFG_STALL] <= 1'b0;
        end
        if (outPacketRx) begin
            outCnt[`CNT_NAK] <= 1'b1;
        end
        inCfg[`CFG_TOGGLE] <= inToggle;
        outCfg[`CFG_TOGGLE] <= outToggle;
    end
end

// ----------------------------------------------------------------
// event flags, set wins over clear
// ----------------------------------------------------------------
assign flagSet[`FLG_OVERWRITE] = setupRx & setupHeld;
assign flagSet[`FLG_WAKEUP] = wakeRise;
assign flagSet[`FLG_SETUP] = setupRx;
assign flagSet[`FLG_RING] = ringRise;
assign flagSet[4] = 1'b0;
assign flagSet[`FLG_RESUME] = resumeSeen;
assign flagSet[`FLG_SUSPEND] = suspendSeen;
assign flagSet[`FLG_RESETREQ] = portReset;
assign flagClr = wrHit[SEL_FLAGS] ? wrData : 8'h0;

always @(posedge clock) begin
    if (sys_rst) begin
        eventFlags <= 8'h0;
        eventMask <= 8'h0;
    end else begin
        eventFlags <= (flagSet | (eventFlags & ~flagClr)) &
            `FLG_USED;
        if (wrHit[SEL_MASK]) begin
            eventMask <= wrData & `FLG_USED;
        end
        // function reset spares the reset request and its mask
        if (funcRst) begin
            eventFlags[6:0] <= 7'h0;
            eventMask[6:0] <= 7'h0;
        end
    end
end

// ----------------------------------------------------------------
// control register, power-up reset only
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        usbControl <= `CTL_RESET;
    end else begin
        if (wrHit[SEL_CTL]) begin
            // writable bits plus a one-shot wakeup request
            usbControl <= (wrData & `CTL_WMASK) |
                (wrData & (8'h1 << `CTL_WAKEUP));
        end else begin
            usbControl[`CTL_WAKEUP] <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// axi read path
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h0;
    end else begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            if (s_axi_araddr[17:2] == `ADDR_IN_CONFIG) begin
                s_axi_rdata <= {24'h0, inCfg};
            end else if (s_axi_araddr[17:2] == `ADDR_IN_COUNT) begin
                s_axi_rdata <= {24'h0, inCnt};
            end else if (s_axi_araddr[17:2] == `ADDR_OUT_CONFIG) begin
                s_axi_rdata <= {24'h0, outCfg};
            end else if (s_axi_araddr[17:2] == `ADDR_OUT_COUNT) begin
                s_axi_rdata <= {24'h0, outCnt};
            end else if (s_axi_araddr[17:2] == `ADDR_CONTROL) begin
                s_axi_rdata <= {24'h0, usbControl};
            end else if (s_axi_araddr[17:2] == `ADDR_MASK) begin
                s_axi_rdata <= {24'h0, eventMask};
            end else if (s_axi_araddr[17:2] == `ADDR_FLAGS) begin
                s_axi_rdata <= {24'h0, eventFlags};
            end else if (s_axi_araddr[17:2] == `ADDR_FUNC) begin
                s_axi_rdata <= {25'h0, funcAddr};
            end else begin
                s_axi_rresp <= 2'h2; // unmapped: slverr
            end
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// registered outputs to the serial engine
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        inNak <= 1'b1;
        outNak <= 1'b1;
        inStall <= 1'b0;
        outStall <= 1'b0;
        inMgrEnable <= 1'b0;
        outMgrEnable <= 1'b0;
        inByteCount <= 4'h0;
        outByteCount <= 4'h0;
        inBufBase <= `IN_BUF_BASE;
        outBufBase <= `OUT_BUF_BASE;
        assignedAddress <= 7'h0;
        dataDirIn <= 1'b0;
        setupService <= 1'b0;
        infraredSelect <= 1'b0;
        pullupEnable <= 1'b0;
        wakeupPulse <= 1'b0;
        mcuReset <= 1'b1;
    end else begin
        inNak <= inCnt[`CNT_NAK] | eventFlags[`FLG_SETUP];
        outNak <= outCnt[`CNT_NAK] | eventFlags[`FLG_SETUP];
        inStall <= inCfg[`CFG_STALL];
        outStall <= outCfg[`CFG_STALL];
        inMgrEnable <= inCfg[`CFG_MGR_EN];
        outMgrEnable <= outCfg[`CFG_MGR_EN];
        inByteCount <= (inCnt[3:0] > `CNT_MAX) ? `CNT_MAX : inCnt[3:0];
        outByteCount <= outCnt[3:0];
        inBufBase <= `IN_BUF_BASE;
        outBufBase <= `OUT_BUF_BASE;
        assignedAddress <= funcAddr;
        dataDirIn <= usbControl[`CTL_DIR];
        setupService <= usbControl[`CTL_SERVICE];
        infraredSelect <= usbControl[6];
        pullupEnable <= usbControl[`CTL_CONNECT];
        wakeupPulse <= usbControl[`CTL_WAKEUP];
        mcuReset <= funcRst & usbControl[`CTL_LINK];
    end
end

// interrupt requests, registered
always @(posedge clock) begin
    if (sys_rst) begin
        epIrq <= 1'b0;
        eventIrq <= 1'b0;
    end else begin
        epIrq <= (inDone & inCfg[`CFG_IRQ_EN]) |
            (outDone & outCfg[`CFG_IRQ_EN]);
        eventIrq <= |(eventFlags & eventMask);
    end
end

endmodule

/* dv/usb_host_model.sv */
// host-side model raising ep0 transaction events
`timescale 1ns/1ns
module usb_host_model (
    input wire clock,
    input wire go,
    input wire [2:0] kind,
    input wire inNak,
    input wire outNak,
    output reg setupRx,
    output reg setupHeld,
    output reg inDone,
    output reg outDone,
    output reg outPacketRx,
    output reg inToggle,
    output reg outToggle,
    output reg suspendSeen,
    output reg resumeSeen,
    output reg portReset
);
    wire inOk;
    wire outOk;
    // a data stage only completes when not nak'd
    assign inOk = go && kind == 3'h1 && !inNak;
    assign outOk = go && kind == 3'h2 && !outNak;
    initial begin
        {setupRx, setupHeld, inDone, outDone, outPacketRx} = 5'h0;
        {inToggle, outToggle, suspendSeen, resumeSeen, portReset} = 5'h0;
    end
    // one-cycle pulses except the held setupHeld level, toggles flip per completed stage
    always @(posedge clock) begin
        setupRx <= go && kind == 3'h0;
        setupHeld <= (setupHeld | setupRx) & !(go && kind == 3'h7);
        inDone <= inOk;
        outDone <= outOk;
        outPacketRx <= go && kind == 3'h3 && !outNak;
        suspendSeen <= go && kind == 3'h4;
        resumeSeen <= go && kind == 3'h5;
        portReset <= go && kind == 3'h6;
        inToggle <= inToggle ^ inOk;
        outToggle <= outToggle ^ outOk;
    end
endmodule

/* dv/usb_ep0_ctrl_asserts.sv */
// port checker for the ep0 register block
`timescale 1ns/1ns
module usb_ep0_ctrl_check (
    input wire clock,
    input wire sys_rst,
    input wire funcRst,
    input wire setupRx,
    input wire inDone,
    input wire outDone,
    input wire inNak,
    input wire outNak,
    input wire inStall,
    input wire outStall,
    input wire [3:0] inByteCount,
    input wire [15:0] inBufBase,
    input wire [15:0] outBufBase,
    input wire wakeupPulse,
    input wire mcuReset,
    input wire epIrq,
    input wire eventIrq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_fixed_base: assert property (
        inBufBase == 16'hfef8 && outBufBase == 16'hfef0)
        else $error("buffer base moved");
    a_in_stall_clear: assert property (
        inStall && setupRx |-> ##[1:4] !inStall)
        else $error("in stall kept after setup");
    a_out_stall_clear: assert property (
        outStall && outDone |-> ##[1:4] !outStall)
        else $error("out stall kept after handshake");
    a_ep_irq_cause: assert property (
        !(inDone || outDone) |=> !epIrq)
        else $error("endpoint irq without completion");
    a_count_sat: assert property (
        inByteCount <= 4'h8)
        else $error("in byte count above eight");
    a_setup_nak: assert property (
        setupRx |-> ##[1:4] (inNak && outNak))
        else $error("setup did not force nak");
    a_mcu_link: assert property (
        !funcRst && !sys_rst |=> !mcuReset)
        else $error("processor reset without function reset");
    a_wake_pulse: assert property (
        wakeupPulse |=> !wakeupPulse)
        else $error("wakeup pulse too long");
    c_ep_irq: cover property (epIrq);
    c_wake: cover property (wakeupPulse);
    c_event: cover property (eventIrq);
endmodule
bind usb_ep0_ctrl usb_ep0_ctrl_check u_check (.clock, .sys_rst,
    .funcRst, .setupRx, .inDone, .outDone, .inNak, .outNak, .inStall,
    .outStall, .inByteCount, .inBufBase, .outBufBase, .wakeupPulse,
    .mcuReset, .epIrq, .eventIrq);

/* dv/tb_usb_ep0_ctrl.sv */
// self-checking bench for the ep0 register block
`timescale 1ns/1ns
module tb_usb_ep0_ctrl;
    logic clock = 0, sys_rst = 1, funcRst = 0, ringPin = 0, wakeupPin = 0;
    logic go = 0;
    logic [2:0] kind = 3'h0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire setupRx, setupHeld, inDone, outDone, outPacketRx, inToggle;
    wire outToggle, suspendSeen, resumeSeen, portReset;
    wire inNak, outNak, inStall, outStall, inMgrEnable, outMgrEnable;
    wire [3:0] inByteCount, outByteCount;
    wire [15:0] inBufBase, outBufBase;
    wire [6:0] assignedAddress;
    wire dataDirIn, setupService, infraredSelect, pullupEnable;
    wire wakeupPulse, mcuReset, epIrq, eventIrq;
    logic [7:0] epCnt = 0, wkCnt = 0, mcuCnt = 0, d, m;
    logic [1:0] r;
    logic [31:0] seed = 13;
    int badCount = 0, nTests = 0, i;
    logic [15:0] ra [8] = '{16'hff80, 16'hff81, 16'hff82, 16'hff83,
        16'hfffc, 16'hfffd, 16'hfffe, 16'hffff};
    logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h00, 8'h80,
        8'h10, 8'h00, 8'h00, 8'h00};
    usb_ep0_ctrl dut (.clock, .sys_rst, .funcRst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .setupRx, .setupHeld, .inDone, .outDone, .outPacketRx, .inToggle,
        .outToggle, .suspendSeen, .resumeSeen, .portReset, .ringPin,
        .wakeupPin, .inNak, .outNak, .inStall, .outStall, .inMgrEnable,
        .outMgrEnable, .inByteCount, .outByteCount, .inBufBase,
        .outBufBase, .assignedAddress, .dataDirIn, .setupService,
        .infraredSelect, .pullupEnable, .wakeupPulse, .mcuReset, .epIrq,
        .eventIrq);
    usb_host_model host (.clock, .go, .kind, .inNak, .outNak, .setupRx,
        .setupHeld, .inDone, .outDone, .outPacketRx, .inToggle,
        .outToggle, .suspendSeen, .resumeSeen, .portReset);
    // 100 MHz clock
    initial forever #5 clock = ~clock;
    // pulse counters for one-cycle outputs
    always @(posedge clock) begin
        if (!sys_rst) begin
            epCnt <= epCnt + {7'h0, epIrq};
            wkCnt <= wkCnt + {7'h0, wakeupPulse};
            mcuCnt <= mcuCnt + {7'h0, mcuReset};
        end
    end
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    function automatic [3:0] sat(input [3:0] c);
        sat = c > 4'h8 ? 4'h8 : c;
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        nTests++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask
    task automatic wr(input [15:0] a, input [7:0] v);
        @(posedge clock);
        s_axi_awaddr <= {14'h0, a, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(input [15:0] a);
        @(posedge clock);
        s_axi_araddr <= {14'h0, a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input [15:0] a, input [7:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic ev(input [2:0] k);
        @(posedge clock);
        go <= 1'b1;
        kind <= k;
        @(posedge clock);
        go <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    task automatic frst;
        @(posedge clock);
        funcRst <= 1'b1;
        @(posedge clock);
        funcRst <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic conclude;
        $display("compares=%0d mismatches=%0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        badCount++;
        conclude;
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) rc(ra[i], rv[i]);
        rd(16'h0010);
        chk(r, 2'h2);
        chk(inBufBase, 16'hfef8);
        chk(outBufBase, 16'hfef0);
        repeat (4) begin
            seed = xs(seed);
            wr(16'hffff, seed[7:0]);
            chk(assignedAddress, seed[6:0]);
        end
        for (i = 0; i < 16; i++) begin
            wr(16'hff81, i[7:0]);
            chk(inByteCount, sat(i[3:0]));
        end
        chk(inNak, 1'b0);
        wr(16'hff80, 8'hff);
        rc(16'hff80, {2'h2, inToggle, 5'h0c});
        chk({inMgrEnable, inStall}, 2'h3);
        ev(3'h0);
        rc(16'hff80, {2'h2, inToggle, 5'h04});
        chk({inNak, outNak}, 2'h3);
        ev(3'h0);
        rc(16'hfffe, 8'h05);
        wr(16'hfffe, 8'h00);
        rc(16'hfffe, 8'h05);
        wr(16'hfffe, 8'h04);
        rc(16'hfffe, 8'h01);
        wr(16'hfffe, 8'h01);
        ev(3'h7);
        m = epCnt;
        ev(3'h1);
        chk(epCnt, m + 8'h1);
        rc(16'hff80, {2'h2, inToggle, 5'h04});
        wr(16'hff80, 8'h80);
        ev(3'h1);
        chk(epCnt, m + 8'h1);
        wr(16'hff83, 8'h05);
        chk({outNak, outByteCount}, 5'h05);
        wr(16'hff82, 8'h88);
        chk({outMgrEnable, outStall}, 2'h3);
        ev(3'h2);
        rc(16'hff82, {2'h2, outToggle, 5'h00});
        ev(3'h3);
        rc(16'hff83, 8'h85);
        wr(16'hfffd, 8'hff);
        for (i = 4; i < 7; i++) ev(i[2:0]);
        ringPin <= 1'b1;
        wakeupPin <= 1'b1;
        repeat (8) @(posedge clock);
        rc(16'hfffe, 8'hea);
        chk(eventIrq, 1'b1);
        wr(16'hfffe, 8'h6a);
        wr(16'hfffd, 8'h7f);
        chk(eventIrq, 1'b0);
        wr(16'hfffd, 8'h80);
        chk(eventIrq, 1'b1);
        wr(16'hfffc, 8'hd3);
        chk({pullupEnable, infraredSelect, setupService, dataDirIn},
            4'hf);
        m = mcuCnt;
        frst;
        chk(mcuCnt, m + 8'h1);
        rc(16'hfffc, 8'hd3);
        rc(16'hfffe, 8'h80);
        rc(16'hfffd, 8'h80);
        rc(16'hff81, 8'h80);
        wr(16'hfffc, 8'h83);
        m = mcuCnt;
        frst;
        chk(mcuCnt, m);
        m = wkCnt;
        wr(16'hfffc, 8'ha3);
        wr(16'hfffc, 8'h83);
        chk(wkCnt, m + 8'h1);
        rc(16'hfffc, 8'h83);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rc(16'hfffc, 8'h10);
        conclude;
    end
endmodule
